//--- wor_defines.svh
`ifndef WOR_DEFINES_SVH
`define WOR_DEFINES_SVH

// ----------------------------------------
// addresses
// ----------------------------------------
`define WOR_ADDR_OPT_TWO 16'h001E
`define WOR_ADDR_OPT_ONE 16'h001F

// ----------------------------------------
// option_register_two bit positions
// ----------------------------------------
`define WOR_TWO_TB_PRESCALE 2
`define WOR_TWO_OSC_STOP 1
`define WOR_TWO_BAUD_SRC 0
`define WOR_TWO_USED_MASK 8'h07
`define WOR_TWO_RESET 8'h01
`define WOR_TWO_KEEP_MASK 8'h00

// ----------------------------------------
// option_register_one bit positions
// ----------------------------------------
`define WOR_ONE_WDOG_RATE 7
`define WOR_ONE_DET_STOP 6
`define WOR_ONE_DET_RSTD 5
`define WOR_ONE_DET_PWRD 4
`define WOR_ONE_DET_VMODE 3
`define WOR_ONE_SHORT_REC 2
`define WOR_ONE_STOP_EN 1
`define WOR_ONE_WDOG_DIS 0
`define WOR_ONE_RESET 8'h00
// voltage mode survives every reset but power-on
`define WOR_ONE_KEEP_MASK 8'h08

// ----------------------------------------
// cycle figures
// ----------------------------------------
`define WOR_WDOG_SHORT 18'h01FF0
`define WOR_WDOG_LONG 18'h3FFF0
`define WOR_REC_SHORT 13'h0020
`define WOR_REC_LONG 13'h1000
`define WOR_TB_EXTRA_DIV 8'h80
`define WOR_TB_NO_DIV 8'h01

`endif

//--- wor_pkg.sv
package wor_pkg;

    typedef struct packed {
        logic wdog_rate_sel;
        logic det_stop_enable;
        logic det_reset_disable;
        logic det_power_disable;
        logic det_voltage_mode;
        logic short_stop_recovery;
        logic stop_instr_enable;
        logic watchdog_disable;
    } wor_one_t;

    typedef struct packed {
        logic [4:0] unused;
        logic timebase_extra_prescale_sel;
        logic osc_run_in_stop;
        logic serial_baud_clock_src;
    } wor_two_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } wor_bus_t;

endpackage

//--- wor_once_reg.sv
`timescale 1ns/1ns
`include "wor_defines.svh"

// one 8-bit register with its own write-once latch
module wor_once_reg #(
    parameter logic [7:0] RESET_VAL = 8'h00,
    parameter logic [7:0] KEEP_MASK = 8'h00
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic por_in,
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] q_out
);
    logic [7:0] val_ff;
    logic [7:0] nxt_val;
    logic used_ff;
    logic nxt_used;

    always_comb begin
        nxt_val = val_ff;
        nxt_used = used_ff;
        if (!nrst_in) begin
            // kept bits survive non-power-on reset
            nxt_val = (val_ff & KEEP_MASK) | (RESET_VAL & ~KEEP_MASK);
            if (por_in) begin
                nxt_val = RESET_VAL;
            end
            nxt_used = 1'b0;
        end else if (wr_in && !used_ff) begin
            nxt_val = wdata_in;
            nxt_used = 1'b1;
        end
        // spent latch: write dropped silently
    end

    always_ff @(posedge clk_in) begin
        val_ff <= nxt_val;
        used_ff <= nxt_used;
    end

    assign q_out = val_ff;
endmodule // wor_once_reg

//--- wor_option_regs.sv
`timescale 1ns/1ns
`include "wor_defines.svh"

module wor_option_regs (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire logic POR_IN,
    // cpu bus
    input wire wor_pkg::wor_bus_t BUS_IN,
    output logic [7:0] RDATA_OUT,
    output logic RVALID_OUT,
    // system inputs
    input wire logic DET_RESET_REQ_IN,
    input wire logic STOP_EXEC_IN,
    // option outputs
    output logic TB_EXTRA_PRESCALE_OUT,
    output logic [7:0] TB_EXTRA_DIV_OUT,
    output logic OSC_RUN_IN_STOP_OUT,
    output logic BAUD_SRC_BUS_OUT,
    output logic [17:0] WDOG_TIMEOUT_OUT,
    output logic WDOG_ENABLE_OUT,
    output logic DET_POWER_ON_OUT,
    output logic DET_RUN_IN_STOP_OUT,
    output logic DET_RESET_OUT,
    output logic DET_5V_MODE_OUT,
    output logic [12:0] STOP_RECOVERY_OUT,
    output logic STOP_ENTER_OUT,
    output logic ILLEGAL_OP_OUT
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // one compare shared by the write strobes and the read mux
    function automatic logic addr_hit(input logic [15:0] addr, input logic [15:0] target);
        addr_hit = (addr == target);
    endfunction

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    wor_pkg::wor_one_t one_q;
    wor_pkg::wor_two_t two_q;
    logic [7:0] one_raw;
    logic [7:0] two_raw;
    logic vmode_used_ff;
    logic nxt_vmode_used;
    logic wr_one;
    logic wr_two;
    logic [7:0] one_wdata;

    // a write during reset is dropped, so it must not spend a latch either
    assign wr_one = BUS_IN.wr && NRST_IN && addr_hit(BUS_IN.addr, `WOR_ADDR_OPT_ONE);
    assign wr_two = BUS_IN.wr && NRST_IN && addr_hit(BUS_IN.addr, `WOR_ADDR_OPT_TWO);

    // ----------------------------------------
    // voltage-mode latch
    // ----------------------------------------
    // voltage mode has its own latch, re-armed only at power-on
    always_comb begin
        nxt_vmode_used = vmode_used_ff;
        one_wdata = BUS_IN.wdata;
        if (vmode_used_ff) begin
            one_wdata[`WOR_ONE_DET_VMODE] = one_raw[`WOR_ONE_DET_VMODE];
        end
        if (!NRST_IN && POR_IN) begin
            nxt_vmode_used = 1'b0;
        end else if (wr_one) begin
            nxt_vmode_used = 1'b1;
        end
    end

    always_ff @(posedge CLK_IN) begin
        vmode_used_ff <= nxt_vmode_used;
    end

    // ----------------------------------------
    // option register instances
    // ----------------------------------------
    wor_once_reg #(
        .RESET_VAL(`WOR_ONE_RESET),
        .KEEP_MASK(`WOR_ONE_KEEP_MASK)
    ) u_one (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .por_in(POR_IN),
        .wr_in(wr_one),
        .wdata_in(one_wdata),
        .q_out(one_raw)
    );

    wor_once_reg #(
        .RESET_VAL(`WOR_TWO_RESET),
        .KEEP_MASK(`WOR_TWO_KEEP_MASK)
    ) u_two (
        .clk_in(CLK_IN),
        .nrst_in(NRST_IN),
        .por_in(POR_IN),
        .wr_in(wr_two),
        .wdata_in(BUS_IN.wdata & `WOR_TWO_USED_MASK),
        .q_out(two_raw)
    );

    assign one_q = wor_pkg::wor_one_t'(one_raw);
    assign two_q = wor_pkg::wor_two_t'(two_raw);

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [7:0] nxt_rdata;
    logic nxt_rvalid;

    // reads never touch the write-once latches
    always_comb begin
        nxt_rvalid = 1'b0;
        nxt_rdata = 8'h00;
        if (NRST_IN) begin
            nxt_rvalid = BUS_IN.rd;
            if (BUS_IN.rd && addr_hit(BUS_IN.addr, `WOR_ADDR_OPT_ONE)) begin
                nxt_rdata = one_raw;
            end else if (BUS_IN.rd && addr_hit(BUS_IN.addr, `WOR_ADDR_OPT_TWO)) begin
                nxt_rdata = two_raw;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        RDATA_OUT <= nxt_rdata;
        RVALID_OUT <= nxt_rvalid;
    end

    // ----------------------------------------
    // decoded option outputs
    // ----------------------------------------
    logic nxt_tb_prescale;
    logic [7:0] nxt_tb_div;
    logic nxt_osc_stop;
    logic nxt_baud_bus;
    logic [17:0] nxt_wdog_timeout;
    logic nxt_wdog_enable;
    logic nxt_det_power_on;
    logic nxt_det_run_stop;
    logic nxt_det_5v;
    logic [12:0] nxt_stop_recovery;

    always_comb begin
        if (!NRST_IN) begin
            // defaults while reset is held
            nxt_tb_prescale = 1'b0;
            nxt_tb_div = `WOR_TB_NO_DIV;
            nxt_osc_stop = 1'b0;
            nxt_baud_bus = 1'b1;
            nxt_wdog_timeout = `WOR_WDOG_LONG;
            nxt_wdog_enable = 1'b1;
            nxt_det_power_on = 1'b1;
            nxt_det_run_stop = 1'b0;
            // trip point must not jump during a plain reset
            nxt_det_5v = POR_IN ? 1'b0 : one_q.det_voltage_mode;
            nxt_stop_recovery = `WOR_REC_LONG;
        end else begin
            nxt_tb_prescale = two_q.timebase_extra_prescale_sel;
            nxt_tb_div = nxt_tb_prescale ? `WOR_TB_EXTRA_DIV : `WOR_TB_NO_DIV;
            nxt_osc_stop = two_q.osc_run_in_stop;
            nxt_baud_bus = two_q.serial_baud_clock_src;
            nxt_wdog_timeout = one_q.wdog_rate_sel ? `WOR_WDOG_SHORT : `WOR_WDOG_LONG;
            nxt_wdog_enable = !one_q.watchdog_disable;
            nxt_det_power_on = !one_q.det_power_disable;
            // stop-enable only counts while the detector is powered
            nxt_det_run_stop = one_q.det_stop_enable && !one_q.det_power_disable;
            nxt_det_5v = one_q.det_voltage_mode;
            nxt_stop_recovery = `WOR_REC_LONG;
            if (one_q.short_stop_recovery) begin
                nxt_stop_recovery = `WOR_REC_SHORT;
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        TB_EXTRA_PRESCALE_OUT <= nxt_tb_prescale;
        TB_EXTRA_DIV_OUT <= nxt_tb_div;
        OSC_RUN_IN_STOP_OUT <= nxt_osc_stop;
        BAUD_SRC_BUS_OUT <= nxt_baud_bus;
        WDOG_TIMEOUT_OUT <= nxt_wdog_timeout;
        WDOG_ENABLE_OUT <= nxt_wdog_enable;
        DET_POWER_ON_OUT <= nxt_det_power_on;
        DET_RUN_IN_STOP_OUT <= nxt_det_run_stop;
        DET_5V_MODE_OUT <= nxt_det_5v;
        STOP_RECOVERY_OUT <= nxt_stop_recovery;
    end

    // ----------------------------------------
    // stop and detector reset events
    // ----------------------------------------
    logic nxt_det_reset;
    logic nxt_stop_enter;
    logic nxt_illegal_op;

    // no stored state here, so reset just forces them low
    always_comb begin
        nxt_det_reset = 1'b0;
        nxt_stop_enter = 1'b0;
        nxt_illegal_op = 1'b0;
        if (NRST_IN) begin
            nxt_det_reset = DET_RESET_REQ_IN && !one_q.det_reset_disable;
            nxt_stop_enter = STOP_EXEC_IN && one_q.stop_instr_enable;
            nxt_illegal_op = STOP_EXEC_IN && !one_q.stop_instr_enable;
        end
    end

    always_ff @(posedge CLK_IN) begin
        DET_RESET_OUT <= nxt_det_reset;
        STOP_ENTER_OUT <= nxt_stop_enter;
        ILLEGAL_OP_OUT <= nxt_illegal_op;
    end
endmodule // wor_option_regs

//--- wor_option_regs_sva.sv
`timescale 1ns/1ns
// ----------------------------------------
// option register checks
// ----------------------------------------
module wor_option_regs_sva (
    // clock, reset, inputs
    input wire logic CLK_IN,
    input wire logic NRST_IN,
    input wire wor_pkg::wor_bus_t BUS_IN,
    input wire logic DET_RESET_REQ_IN,
    input wire logic STOP_EXEC_IN,
    // outputs watched
    input wire logic RVALID_OUT,
    input wire logic TB_EXTRA_PRESCALE_OUT,
    input wire logic [7:0] TB_EXTRA_DIV_OUT,
    input wire logic BAUD_SRC_BUS_OUT,
    input wire logic [17:0] WDOG_TIMEOUT_OUT,
    input wire logic DET_POWER_ON_OUT,
    input wire logic DET_RUN_IN_STOP_OUT,
    input wire logic DET_RESET_OUT,
    input wire logic [12:0] STOP_RECOVERY_OUT,
    input wire logic STOP_ENTER_OUT,
    input wire logic ILLEGAL_OP_OUT
);
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!NRST_IN);
    a_read_answer: assert property (BUS_IN.rd |=> RVALID_OUT)
        else $error("read without valid");
    a_no_stray_valid: assert property (RVALID_OUT |-> $past(BUS_IN.rd))
        else $error("valid without read");
    a_reset_defaults: assert property ($rose(NRST_IN) |->
        BAUD_SRC_BUS_OUT && WDOG_TIMEOUT_OUT == 18'h3FFF0)
        else $error("bad defaults after reset");
    a_wdog_values: assert property (WDOG_TIMEOUT_OUT == 18'h01FF0 ||
        WDOG_TIMEOUT_OUT == 18'h3FFF0)
        else $error("bad watchdog timeout");
    a_rec_values: assert property (STOP_RECOVERY_OUT == 13'h0020 ||
        STOP_RECOVERY_OUT == 13'h1000)
        else $error("bad recovery length");
    a_div_tracks: assert property (TB_EXTRA_DIV_OUT ==
        (TB_EXTRA_PRESCALE_OUT ? 8'h80 : 8'h01))
        else $error("divider and select disagree");
    a_once_stable: assert property (!($past(BUS_IN.wr, 2) &&
        $past(BUS_IN.addr, 2) == 16'h001F) |->
        $stable(WDOG_TIMEOUT_OUT) && $stable(STOP_RECOVERY_OUT))
        else $error("option output moved without a write");
    a_det_stop_power: assert property (DET_RUN_IN_STOP_OUT |-> DET_POWER_ON_OUT)
        else $error("detector in stop while off");
    a_det_reset_cause: assert property (DET_RESET_OUT |-> $past(DET_RESET_REQ_IN))
        else $error("detector reset without request");
    a_stop_split: assert property ((STOP_ENTER_OUT || ILLEGAL_OP_OUT) |->
        $past(STOP_EXEC_IN) && !(STOP_ENTER_OUT && ILLEGAL_OP_OUT))
        else $error("stop outcome wrong");
endmodule // wor_option_regs_sva

bind wor_option_regs wor_option_regs_sva sva_u (.CLK_IN(CLK_IN), .NRST_IN(NRST_IN),
    .BUS_IN(BUS_IN), .DET_RESET_REQ_IN(DET_RESET_REQ_IN), .STOP_EXEC_IN(STOP_EXEC_IN),
    .RVALID_OUT(RVALID_OUT), .TB_EXTRA_PRESCALE_OUT(TB_EXTRA_PRESCALE_OUT),
    .TB_EXTRA_DIV_OUT(TB_EXTRA_DIV_OUT), .BAUD_SRC_BUS_OUT(BAUD_SRC_BUS_OUT),
    .WDOG_TIMEOUT_OUT(WDOG_TIMEOUT_OUT), .DET_POWER_ON_OUT(DET_POWER_ON_OUT),
    .DET_RUN_IN_STOP_OUT(DET_RUN_IN_STOP_OUT), .DET_RESET_OUT(DET_RESET_OUT),
    .STOP_RECOVERY_OUT(STOP_RECOVERY_OUT), .STOP_ENTER_OUT(STOP_ENTER_OUT),
    .ILLEGAL_OP_OUT(ILLEGAL_OP_OUT));

//--- write_once_option_registers_tb.sv
`timescale 1ns/1ns
module write_once_option_registers_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic por = 1'b1;
    logic req = 1'b0;
    logic stp = 1'b0;
    wor_pkg::wor_bus_t bus = '0;
    logic [7:0] rdata;
    logic [7:0] div;
    logic [17:0] wto;
    logic [12:0] rec;
    logic rvalid, tbp, osc, baud, wen, pon, dst, drs, d5, sen, ill;
    int mismatches = 0;
    int checked = 0;
    always #5 clk = ~clk;
    wor_option_regs dut_u (.CLK_IN(clk), .NRST_IN(nrst), .POR_IN(por), .BUS_IN(bus),
        .RDATA_OUT(rdata), .RVALID_OUT(rvalid), .DET_RESET_REQ_IN(req), .STOP_EXEC_IN(stp),
        .TB_EXTRA_PRESCALE_OUT(tbp), .TB_EXTRA_DIV_OUT(div), .OSC_RUN_IN_STOP_OUT(osc),
        .BAUD_SRC_BUS_OUT(baud), .WDOG_TIMEOUT_OUT(wto), .WDOG_ENABLE_OUT(wen),
        .DET_POWER_ON_OUT(pon), .DET_RUN_IN_STOP_OUT(dst), .DET_RESET_OUT(drs),
        .DET_5V_MODE_OUT(d5), .STOP_RECOVERY_OUT(rec), .STOP_ENTER_OUT(sen),
        .ILLEGAL_OP_OUT(ill));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = '{1'b1, 1'b0, a, d};
        @(negedge clk);
        bus = '0;
    endtask
    // data is registered, so it is looked at one cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        bus = '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        bus = '0;
        chk("rdata", 18'(rdata), 18'(e));
        chk("rvalid", 18'(rvalid), 18'h00001);
    endtask
    task automatic rst(input logic p);
        @(negedge clk);
        por = p;
        nrst = 1'b0;
        repeat (8) @(negedge clk);
        nrst = 1'b1;
        por = 1'b0;
    endtask
    task automatic pulse;
        @(negedge clk);
        stp = 1'b1;
        req = 1'b1;
        @(negedge clk);
        stp = 1'b0;
        req = 1'b0;
    endtask
    task automatic conclude;
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        rst(1'b1);
        rd(16'h001E, 8'h01);
        rd(16'h001F, 8'h00);
        chk("wdog", wto, 18'h3FFF0);
        chk("rec", 18'(rec), 18'h01000);
        chk("osc", 18'(osc), 18'h00000);
        chk("tbp", 18'(tbp), 18'h00000);
        wr(16'h001F, 8'hCE);
        wr(16'h001F, 8'h31);
        rd(16'h001F, 8'hCE);
        rd(16'h001E, 8'h01);
        chk("wdog", wto, 18'h01FF0);
        chk("rec", 18'(rec), 18'h00020);
        chk("d5", 18'(d5), 18'h00001);
        chk("dst", 18'(dst), 18'h00001);
        chk("wen", 18'(wen), 18'h00001);
        wr(16'h001E, 8'hFE);
        wr(16'h001E, 8'h00);
        rd(16'h001E, 8'h06);
        chk("div", 18'(div), 18'h00080);
        chk("tbp", 18'(tbp), 18'h00001);
        chk("osc", 18'(osc), 18'h00001);
        chk("baud", 18'(baud), 18'h00000);
        pulse;
        chk("sen", 18'(sen), 18'h00001);
        chk("drs", 18'(drs), 18'h00001);
        chk("ill", 18'(ill), 18'h00000);
        rd(16'h0020, 8'h00);
        // plain reset keeps voltage mode and does not re-arm its write
        rst(1'b0);
        rd(16'h001F, 8'h08);
        chk("d5", 18'(d5), 18'h00001);
        wr(16'h001F, 8'h75);
        rd(16'h001F, 8'h7D);
        pulse;
        chk("ill", 18'(ill), 18'h00001);
        chk("sen", 18'(sen), 18'h00000);
        chk("drs", 18'(drs), 18'h00000);
        chk("pon", 18'(pon), 18'h00000);
        chk("dst", 18'(dst), 18'h00000);
        chk("wen", 18'(wen), 18'h00000);
        rst(1'b1);
        rd(16'h001F, 8'h00);
        chk("d5", 18'(d5), 18'h00000);
        wr(16'h001F, 8'h08);
        rd(16'h001F, 8'h08);
        chk("d5", 18'(d5), 18'h00001);
        conclude;
    end
endmodule // write_once_option_registers_tb
